// ===== src/smb_defs.vh
/*
 * Shared constants for the bus slave register port: slave addresses,
 * configuration bit position, pointer reset value and timing figures.
 * Assumes it is included by bare name from files under src/.
 */
`ifndef SMB_DEFS_VH
`define SMB_DEFS_VH

// ************************************************************
// Slave addresses
// ************************************************************
`define SMB_ADDR_DEFAULT 7'h2E
`define SMB_ADDR_SEL_LO 7'h2C
`define SMB_ADDR_SEL_HI 7'h2D

// ************************************************************
// Register space
// ************************************************************
`define SMB_CFG1_REG 8'h40
`define SMB_BUS_TIMEOUT_DISABLE_BIT 6
`define SMB_PTR_RESET 8'h00

// ************************************************************
// Timing
// ************************************************************
`define SMB_CLK_KHZ 200000
`define SMB_TIMEOUT_MS 35
`define SMB_TIMEOUT_CYC (`SMB_TIMEOUT_MS * `SMB_CLK_KHZ)
`define SMB_STRAP_WAIT 3'h4

`endif

// ===== src/smb_fifo.v
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module smb_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // Clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] store [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = store[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @(posedge clk_sys) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// ===== src/smb_regmem.v
/*
 * Internal register space of the monitor: one write port, one read
 * port whose data come out of a register. Assumes a single clock.
 */
`timescale 1ns/1ps
`default_nettype none

module smb_regmem #(
   parameter AW = 8,
   parameter DW = 8
) (
   // Clock
   input wire clk_sys,
   // Write port
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [DW-1:0] wr_data,
   // Read port
   input wire [AW-1:0] rd_addr,
   output reg [DW-1:0] rd_data
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule

`default_nettype wire

// ===== src/smb_slave.v
/*
 * Slave side of the serial management bus for the register port:
 * address strapping, start/stop detection, address and ack phase,
 * send byte, write byte, read byte and receive byte, bus timeout.
 * Assumes clk_sys far faster than the bus clock; bus pins are
 * asynchronous and open drain with an external pullup.
 */
// What this block does
// - Strap pin high at power-up selects slave address 0x2E.
// - Strap pin low selects by second pin: low 0x2C, high 0x2D.
// - Straps sampled at power-up; address latched at eighth rise of first match.
// - Start: data falls while clock high; then seven address bits, MSB first, plus direction.
// - Matching address is acked low before ninth pulse; else idle until next start.
// - Direction 0 is master write, 1 is master read.
// - Each byte is eight data pulses plus one acknowledge pulse.
// - Data changes only with clock low; data rising with clock high is stop.
// - Direction is fixed per operation; changing it needs a new start.
// - Writes carry one or two bytes; reads return exactly one byte.
// - First write byte loads the pointer; second is stored at the pointer.
// - Read returns the register the pointer selects, no pointer write needed.
// - Send byte updates only the pointer and is acknowledged.
// - Read byte: write address, command, repeated start, read address, one byte.
// - Write byte acks address, command and data bytes in turn.
// - Repeated start acts as a fresh start and keeps the pointer.
// - Receive byte returns the register set earlier by send or write byte.
// - No bus activity for 35 ms releases the data line and drops the transfer.
// - Timeout on by default, off when bit 6 of register 0x40 is set.
`timescale 1ns/1ps
`default_nettype none
`include "smb_defs.vh"

module smb_slave #(
   parameter TIMEOUT_CYC = `SMB_TIMEOUT_CYC,
   parameter TO_W = 23,
   parameter FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // Bus pins
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_n,
   // Address straps
   input wire address_strap_enable_pin,
   input wire address_select_pin,
   // Status
   output reg [6:0] slave_addr,
   output reg addr_locked,
   output reg bus_timeout_disable
);

   // ************************************************************
   // States
   // ************************************************************
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_ACK = 3'h2;
   localparam ST_WRX = 3'h3;
   localparam ST_RTX = 3'h4;
   localparam ST_RACK = 3'h5;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   // Order: scl, sda, strap enable, strap select
   reg [3:0] sync1;
   reg [3:0] sync2;
   reg [3:0] sync3;
   reg [3:0] flt;
   wire [3:0] agree;

   assign agree = ~(sync2 ^ sync3);

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sync1 <= 4'hF;
         sync2 <= 4'hF;
         sync3 <= 4'hF;
         flt <= 4'hF;
      end else begin
         sync1 <= {address_select_pin, address_strap_enable_pin, sda_in, scl_in};
         sync2 <= sync1;
         sync3 <= sync2;
         flt <= (sync3 & agree) | (flt & ~agree);
      end
   end

   wire scl_f = flt[0];
   wire sda_f = flt[1];
   reg scl_p;
   reg sda_p;
   wire scl_rise = scl_f && !scl_p;
   wire scl_fall = !scl_f && scl_p;
   wire bus_start = scl_f && scl_p && sda_p && !sda_f;
   wire bus_stop = scl_f && scl_p && !sda_p && sda_f;

   // ************************************************************
   // Power-up strap capture
   // ************************************************************
   reg [2:0] strap_wait;
   reg strap_done;
   reg [6:0] cand_addr;
   wire [6:0] own_addr = addr_locked ? slave_addr : cand_addr;

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         strap_wait <= 3'h0;
         strap_done <= 1'b0;
         cand_addr <= `SMB_ADDR_DEFAULT;
      end else if (!strap_done) begin
         // Wait until the filtered straps have settled
         if (strap_wait == `SMB_STRAP_WAIT) begin
            strap_done <= 1'b1;
            if (flt[2]) begin
               cand_addr <= `SMB_ADDR_DEFAULT;
            end else if (flt[3]) begin
               cand_addr <= `SMB_ADDR_SEL_HI;
            end else begin
               cand_addr <= `SMB_ADDR_SEL_LO;
            end
         end else begin
            strap_wait <= strap_wait + 3'h1;
         end
      end
   end

   // ************************************************************
   // Write path and register space
   // ************************************************************
   reg [7:0] ptr;
   reg wr_push;
   reg [15:0] wr_word;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [15:0] fifo_out_data;
   wire [7:0] rd_data;
   reg [2:0] state;
   // Hold writes back while a read byte is on the wire, so the shifted
   // value never races a pending store to the same register.
   wire drain_ready = (state != ST_RTX) && (state != ST_RACK);
   wire drain = fifo_out_valid && drain_ready;

   smb_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH),
      .AW(4)
   ) u_fifo (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .in_valid(wr_push),
      .in_ready(fifo_in_ready),
      .in_data(wr_word),
      .out_valid(fifo_out_valid),
      .out_ready(drain_ready),
      .out_data(fifo_out_data)
   );

   smb_regmem #(
      .AW(8),
      .DW(8)
   ) u_mem (
      .clk_sys(clk_sys),
      .wr_en(drain),
      .wr_addr(fifo_out_data[15:8]),
      .wr_data(fifo_out_data[7:0]),
      .rd_addr(ptr),
      .rd_data(rd_data)
   );

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         bus_timeout_disable <= 1'b0;
      end else if (drain && fifo_out_data[15:8] == `SMB_CFG1_REG) begin
         bus_timeout_disable <= fifo_out_data[8 + `SMB_BUS_TIMEOUT_DISABLE_BIT - 8];
      end
   end

   // ************************************************************
   // Bus timeout
   // ************************************************************
   reg [TO_W-1:0] idle_cnt;
   wire bus_moved = (scl_f != scl_p) || (sda_f != sda_p);
   wire timed_out = (idle_cnt == TIMEOUT_CYC[TO_W-1:0] - 1'b1);

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         idle_cnt <= {TO_W{1'b0}};
      end else if (bus_moved || state == ST_IDLE || bus_timeout_disable) begin
         idle_cnt <= {TO_W{1'b0}};
      end else if (!timed_out) begin
         idle_cnt <= idle_cnt + 1'b1;
      end else begin
         idle_cnt <= {TO_W{1'b0}};
      end
   end

   // ************************************************************
   // Protocol engine
   // ************************************************************
   reg [7:0] shift;
   reg [3:0] bit_cnt;
   reg rw;
   reg addr_hit;
   reg [1:0] wr_idx;

   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         scl_p <= 1'b1;
         sda_p <= 1'b1;
         state <= ST_IDLE;
         shift <= 8'h00;
         bit_cnt <= 4'h0;
         rw <= 1'b0;
         addr_hit <= 1'b0;
         wr_idx <= 2'h0;
         ptr <= `SMB_PTR_RESET;
         wr_push <= 1'b0;
         wr_word <= 16'h0000;
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
         slave_addr <= `SMB_ADDR_DEFAULT;
         addr_locked <= 1'b0;
      end else begin
         scl_p <= scl_f;
         sda_p <= sda_f;
         wr_push <= 1'b0;
         if (!addr_locked) begin
            slave_addr <= cand_addr;
         end
         if (!strap_done) begin
            state <= ST_IDLE;
         end else if (bus_start) begin
            // Repeated start behaves like a fresh one; pointer kept
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            wr_idx <= 2'h0;
            sda_oe_n <= 1'b1;
         end else if (bus_stop || timed_out) begin
            state <= ST_IDLE;
            sda_oe_n <= 1'b1;
         end else begin
            case (state)
               ST_ADDR: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_f};
                     bit_cnt <= bit_cnt + 4'h1;
                     if (bit_cnt == 4'h7) begin
                        rw <= sda_f;
                        addr_hit <= (shift[6:0] == own_addr);
                        if (shift[6:0] == own_addr && !addr_locked) begin
                           addr_locked <= 1'b1;
                           slave_addr <= own_addr;
                        end
                     end
                  end else if (scl_fall && bit_cnt == 4'h8) begin
                     if (addr_hit) begin
                        state <= ST_ACK;
                        sda_oe_n <= 1'b0;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     // Ninth pulse done: hand the line back or drive data
                     bit_cnt <= 4'h0;
                     if (rw) begin
                        state <= ST_RTX;
                        shift <= {rd_data[6:0], 1'b1};
                        sda_oe_n <= rd_data[7];
                     end else begin
                        state <= ST_WRX;
                        sda_oe_n <= 1'b1;
                     end
                  end
               end
               ST_WRX: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda_f};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == 4'h8) begin
                     if (wr_idx == 2'h0) begin
                        ptr <= shift;
                        wr_idx <= 2'h1;
                        state <= ST_ACK;
                        sda_oe_n <= 1'b0;
                     end else if (wr_idx == 2'h1 && fifo_in_ready) begin
                        wr_push <= 1'b1;
                        wr_word <= {ptr, shift};
                        wr_idx <= 2'h2;
                        state <= ST_ACK;
                        sda_oe_n <= 1'b0;
                     end else begin
                        // Third byte, or no room to store: refuse it
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_RTX: begin
                  if (scl_rise) begin
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_cnt == 4'h8) begin
                        state <= ST_RACK;
                        sda_oe_n <= 1'b1;
                     end else begin
                        shift <= {shift[6:0], 1'b1};
                        sda_oe_n <= shift[7];
                     end
                  end
               end
               ST_RACK: begin
                  // One byte per read; ack or not, the line stays ours no more
                  if (scl_fall) begin
                     state <= ST_IDLE;
                  end
               end
               default: begin
                  state <= ST_IDLE;
                  sda_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// ===== test/smb_mst.sv
/* Bus master model: open-drain clock and data driven in quarter-bit steps.
   Assumes pullups on both lines; the bench resolves the data wire. */
`timescale 1ns/1ps
`default_nettype none
module smb_mst (
   // Clock
   input wire logic clk_sys,
   // Bus
   input wire logic sda_line,
   output var logic scl_o,
   output var logic sda_o
);
   // Quarter bit in system clocks; one extra low-phase clock makes a 65 ns
   // bus clock, the nearest to 64 ns that falling-edge steps allow
   localparam int Q = 3;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic qw();
      repeat (Q) @(negedge clk_sys);
   endtask
   // Also a repeated start when entered with the clock low
   task automatic start();
      sda_o = 1'b1;
      qw();
      scl_o = 1'b1;
      qw();
      sda_o = 1'b0;
      qw();
      scl_o = 1'b0;
      qw();
   endtask
   task automatic stop();
      sda_o = 1'b0;
      qw();
      scl_o = 1'b1;
      qw();
      sda_o = 1'b1;
      qw();
   endtask
   // Nine pulses, MSB first, bit 0 is the ack slot
   task automatic xb(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_o = tx[i];
         qw();
         scl_o = 1'b1;
         qw();
         rx[i] = sda_line;
         qw();
         scl_o = 1'b0;
         qw();
         // Slave moves data five clocks after the fall: keep the low phase longer
         @(negedge clk_sys);
      end
   endtask
endmodule
`default_nettype wire

// ===== test/smb_slave_chk.sv
/* Checker for the bus slave register port, bound to its top.
   Assumes raw pin levels at scl_in and sda_in. */
`timescale 1ns/1ps
`default_nettype none
module smb_slave_chk #(
   parameter int TIMEOUT_CYC = 200
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   // Straps and status
   input wire logic address_strap_enable_pin,
   input wire logic address_select_pin,
   input wire logic [6:0] slave_addr,
   input wire logic addr_locked,
   input wire logic bus_timeout_disable
);
   logic scl_q;
   logic sda_q;
   logic [31:0] idle_cnt;
   logic [3:0] rst_age;
   wire logic [6:0] pick = address_strap_enable_pin ? 7'h2E :
      (address_select_pin ? 7'h2D : 7'h2C);
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         idle_cnt <= 32'h0;
         rst_age <= 4'h0;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         idle_cnt <= (scl_in != scl_q || sda_in != sda_q) ? 32'h0 : idle_cnt + 32'h1;
         rst_age <= (rst_age == 4'hF) ? rst_age : rst_age + 4'h1;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence s_held;
      !sda_oe_n [*8];
   endsequence
   sequence s_quiet_off;
      bus_timeout_disable && idle_cnt > 32'd30;
   endsequence
   // ********
   // Assertions
   // ********
   a_drive_zero: assert property (!sda_oe_n |-> !sda_out)
      else $error("data driven high");
   a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("data drive moved while clock high");
   a_lock_holds: assert property (addr_locked |=> addr_locked)
      else $error("address lock dropped");
   a_addr_frozen: assert property (addr_locked |=> $stable(slave_addr))
      else $error("locked address changed");
   a_addr_legal: assert property (slave_addr inside {7'h2C, 7'h2D, 7'h2E})
      else $error("slave address outside strap set");
   a_strap_pick: assert property (rst_age == 4'hE && !addr_locked |-> slave_addr == pick)
      else $error("slave address not the strap choice");
   a_drive_hold: assert property ($fell(sda_oe_n) |-> s_held)
      else $error("data drive shorter than a clock phase");
   a_timeout_free: assert property (!bus_timeout_disable &&
      idle_cnt == TIMEOUT_CYC + 12 |-> sda_oe_n) else $error("bus not released on timeout");
   a_timeout_off: assert property (s_quiet_off |=> $stable(sda_oe_n))
      else $error("drive changed with timeout disabled");
endmodule
bind smb_slave smb_slave_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .address_strap_enable_pin(address_strap_enable_pin),
   .address_select_pin(address_select_pin), .slave_addr(slave_addr),
   .addr_locked(addr_locked), .bus_timeout_disable(bus_timeout_disable));
`default_nettype wire

// ===== test/smb_slave_register_port_bench.sv
/* Self-checking bench for the bus slave register port with a master model.
   Assumes the design and its include path are compiled beforehand. */
`timescale 1ns/1ps
`default_nettype none
module smb_slave_register_port_bench;
   localparam int TO = 200;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic strap_en = 1'b1;
   logic strap_sel = 1'b0;
   int err_count = 0;
   int samples_checked = 0;
   logic [8:0] rx;
   logic [8:0] r;
   logic [3:0] ak;
   wire logic scl;
   wire logic sda_m;
   wire logic sda_oe_n;
   wire logic sda_out;
   wire logic locked;
   wire logic to_dis;
   wire logic [6:0] saddr;
   // Open drain with pullup
   wire logic sda_line = sda_m & (sda_oe_n | sda_out);
   always #2.5 clk_sys = ~clk_sys;
   smb_mst mst (.clk_sys(clk_sys), .sda_line(sda_line), .scl_o(scl), .sda_o(sda_m));
   smb_slave #(.TIMEOUT_CYC(TO)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .address_strap_enable_pin(strap_en), .address_select_pin(strap_sel),
      .slave_addr(saddr), .addr_locked(locked), .bus_timeout_disable(to_dis));
   // ********
   // Helpers
   // ********
   task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic close_out();
      if (err_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic rst(input logic en, input logic sel);
      strap_en = en;
      strap_sel = sel;
      sys_rst = 1'b1;
      repeat (20) @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (20) @(negedge clk_sys);
   endtask
   // Acks as {address, byte1, byte2, byte3}, unsent bytes read as 1
   task automatic wr(input logic [6:0] a, input logic [23:0] b, input int n);
      mst.start();
      mst.xb({a, 2'b01}, rx);
      ak = {rx[0], 3'b111};
      for (int i = 0; i < n; i++) begin
         mst.xb({b[23-8*i -: 8], 1'b1}, rx);
         ak[2-i] = rx[0];
      end
      mst.stop();
   endtask
   // Returns {data, address ack}; optional command then repeated start
   task automatic rd(input logic [6:0] a, input logic cmd, input logic [7:0] p);
      mst.start();
      if (cmd) begin
         mst.xb({a, 2'b01}, rx);
         mst.xb({p, 1'b1}, rx);
         mst.start();
      end
      mst.xb({a, 2'b11}, rx);
      r[0] = rx[0];
      mst.xb(9'h1FF, rx);
      r[8:1] = rx[8:1];
      mst.stop();
   endtask
   // ********
   // Scenarios
   // ********
   task automatic t_write();
      wr(7'h2E, 24'h005A00, 2);
      chk({5'h0, ak}, 9'h001, "write byte acks");
      chk({8'h0, locked}, 9'h001, "address lock");
      wr(7'h2E, 24'h103500, 2);
      wr(7'h2E, 24'h201122, 3);
      chk({5'h0, ak}, 9'h001, "third byte refused");
      wr(7'h2C, 24'h107700, 2);
      chk({5'h0, ak}, 9'h00F, "foreign address");
   endtask
   task automatic t_straps();
      logic [6:0] exp [3] = '{7'h2C, 7'h2D, 7'h2E};
      for (int i = 0; i < 3; i++) begin
         rst(i[1], i[0]);
         chk({2'h0, saddr}, {2'h0, exp[i]}, "strap address");
         wr(exp[i], 24'h000000, 1);
         chk({5'h0, ak}, 9'h003, "strap address ack");
         strap_en = ~strap_en;
         strap_sel = ~strap_sel;
         repeat (20) @(negedge clk_sys);
         chk({2'h0, saddr}, {2'h0, exp[i]}, "address after pin change");
      end
      rst(1'b1, 1'b0);
      rd(7'h2E, 1'b0, 8'h00);
      chk(r, 9'h0B4, "pointer after reset");
   endtask
   task automatic t_rdbyte();
      rd(7'h2E, 1'b1, 8'h10);
      chk(r, 9'h06A, "read byte");
      rd(7'h2E, 1'b0, 8'h00);
      chk(r, 9'h06A, "receive byte again");
      wr(7'h2E, 24'h20FF00, 1);
      rd(7'h2E, 1'b0, 8'h00);
      chk(r, 9'h022, "send byte then read");
   endtask
   // Stall with the device driving a zero bit, timeout on then off
   task automatic t_timeout();
      for (int k = 0; k < 2; k++) begin
         wr(7'h2E, 24'h100000, 1);
         mst.start();
         mst.xb({7'h2E, 2'b11}, rx);
         repeat (TO + 60) @(negedge clk_sys);
         chk({8'h0, sda_oe_n}, {8'h0, k == 0}, "drive after stall");
         if (k == 1) begin
            mst.xb(9'h1FF, rx);
            chk({rx[8:1], 1'b0}, 9'h06A, "read after stall");
         end
         mst.stop();
         wr(7'h2E, 24'h404000, 2);
         repeat (20) @(negedge clk_sys);
         chk({8'h0, to_dis}, 9'h001, "timeout disable bit");
      end
   endtask
   initial begin
      rst(1'b1, 1'b0);
      t_write();
      t_straps();
      t_rdbyte();
      t_timeout();
      close_out();
   end
   initial begin
      repeat (100000) @(posedge clk_sys);
      err_count++;
      close_out();
   end
endmodule
`default_nettype wire
